//--- delay_cfg_pkg.sv
/*
  Shared constants for the delay configuration block: register offsets,
  field positions, reset values, limits and the frame-delay rate tables.
  Assumes nothing of its surroundings; compiled before every other file.
*/
package delay_cfg_pkg;
  // register offsets as seen through the serial control port
  localparam logic [7:0] OFS_CONTROL    = 8'h01;
  localparam logic [7:0] OFS_RDELAY_HI  = 8'h02;
  localparam logic [7:0] OFS_RDELAY_LO  = 8'h03;
  localparam logic [7:0] OFS_LDELAY_HI  = 8'h04;
  localparam logic [7:0] OFS_LDELAY_LO  = 8'h05;
  localparam logic [7:0] OFS_FRAME      = 8'h06;
  localparam logic [7:0] OFS_WORD_WIDTH = 8'h07;
  localparam logic [7:0] OFS_COMMIT     = 8'h08;
  // every register starts at zero
  localparam logic [7:0] REG_RESET      = 8'h00;
  // control register fields
  localparam int CTRL_MUTE_R_BIT = 7;
  localparam int CTRL_MUTE_L_BIT = 6;
  localparam logic [1:0] RIGHT_JUSTIFIED_FORMAT = 2'h1;
  // commit register field
  localparam int COMMIT_BIT = 0;
  // frame-delay register fields
  localparam int FRAME_EN_BIT   = 7;
  localparam int FRAME_RATE_BIT = 6;
  // word width field and its limit
  localparam int         WW_FIELD_W = 6;
  localparam logic [5:0] WW_MAX     = 6'h18;
  // delay width and its limit in samples
  localparam int          DLY_W   = 13;
  localparam logic [12:0] DLY_MAX = 13'h1FFF;
  // sample rate per 3-bit code, in units of 10 Hz
  localparam int FS10_TAB [8] = '{3200, 4410, 4800, 8820, 9600, 17640, 19200, 19200};
  // frame rates in units of 0.01 Hz
  localparam int RATE100_50 = 5000;
  localparam int RATE100_60 = 5994;
endpackage

//--- engine_cfg_if.sv
/*
  Carrier for the settings held by the delay engine side, plus the
  one-cycle commit pulse. Driven by the commit unit, read by the top and
  the per-channel mute timers; all on sys_clk.
*/
`timescale 1ns/1ps
interface engine_cfg_if;
  logic [1:0]  fmt;        // committed stream format
  logic [4:0]  word_width; // effective packet length, 0 unless right justified
  logic [12:0] delay_l;    // committed left delay in samples
  logic [12:0] delay_r;    // committed right delay in samples
  logic        commit;     // one-cycle pulse after each transfer
  modport src (output fmt, word_width, delay_l, delay_r, commit);
  modport dst (input fmt, word_width, delay_l, delay_r, commit);
endinterface

//--- settings_commit_unit.sv
/*
  Copies the register-file settings into the engine in a single step when
  a commit request arrives. Assumes the request is a one-cycle pulse and
  the register inputs are stable flops of the register file.
*/
`timescale 1ns/1ps
module settings_commit_unit (
  input  wire logic       sys_clk_i,    // system clock
  input  wire logic       rst_i,        // synchronous reset, high
  input  wire logic       commit_req_i, // one-cycle commit request
  input  wire logic [7:0] ctrl_i,       // control register
  input  wire logic [7:0] rdly_hi_i,    // right delay upper
  input  wire logic [7:0] rdly_lo_i,    // right delay lower
  input  wire logic [7:0] ldly_hi_i,    // left delay upper
  input  wire logic [7:0] ldly_lo_i,    // left delay lower
  input  wire logic [7:0] frame_i,      // frame delay register
  input  wire logic [7:0] width_i,      // word width register
  engine_cfg_if.src       cfg           // committed settings
);
  // field value taken directly, limited to the maximum width
  function automatic logic [4:0] clamp_width(input logic [5:0] raw);
    return (raw > delay_cfg_pkg::WW_MAX) ? delay_cfg_pkg::WW_MAX[4:0] : raw[4:0];
  endfunction

  // frames * fs / frame rate, floored, held to the delay ceiling
  function automatic logic [12:0] frame_samples(input logic [7:0] f);
    int fs10;
    int rate;
    int n;
    int s;
    fs10 = delay_cfg_pkg::FS10_TAB[f[5:3]];
    rate = f[delay_cfg_pkg::FRAME_RATE_BIT] ? delay_cfg_pkg::RATE100_60
                                             : delay_cfg_pkg::RATE100_50;
    n    = int'(f[2:0]) + 1;
    s    = (n * fs10 * 1000) / rate;
    return (s > int'(delay_cfg_pkg::DLY_MAX)) ? delay_cfg_pkg::DLY_MAX : 13'(s);
  endfunction

  logic        frame_en;
  logic [12:0] frame_dly;
  logic [4:0]  width_eff;
  assign frame_en  = frame_i[delay_cfg_pkg::FRAME_EN_BIT];
  assign frame_dly = frame_samples(frame_i);
  // width only matters in right justified format
  assign width_eff = (ctrl_i[1:0] == delay_cfg_pkg::RIGHT_JUSTIFIED_FORMAT)
                     ? clamp_width(width_i[5:0]) : 5'h0;

  // all engine settings move together on the request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg.fmt        <= 2'h0;
      cfg.word_width <= 5'h0;
      cfg.delay_l    <= 13'h0;
      cfg.delay_r    <= 13'h0;
    end else if (commit_req_i) begin
      cfg.fmt        <= ctrl_i[1:0];
      cfg.word_width <= width_eff;
      // per-channel registers are masked in frame mode
      cfg.delay_l    <= frame_en ? frame_dly : {ldly_hi_i[4:0], ldly_lo_i};
      cfg.delay_r    <= frame_en ? frame_dly : {rdly_hi_i[4:0], rdly_lo_i};
    end
  end

  // commit pulse follows the transfer by the same edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) cfg.commit <= 1'b0;
    else       cfg.commit <= commit_req_i;
  end

  chk_frame_mask:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req_i && frame_en |=> cfg.delay_l == cfg.delay_r && cfg.delay_l == $past(frame_dly))
    else $error("frame delay did not replace per-channel delay");
endmodule

//--- channel_mute_timer.sv
/*
  Holds one channel muted after a commit until its new delay has filled.
  Assumes sample_tick_i pulses once per audio sample on sys_clk.
*/
`timescale 1ns/1ps
module channel_mute_timer #(
  parameter bit LEFT = 1'b1 // channel served by this instance
) (
  input  wire logic sys_clk_i,     // system clock
  input  wire logic rst_i,         // synchronous reset, high
  input  wire logic sample_tick_i, // one pulse per audio sample
  engine_cfg_if.dst cfg,           // committed settings
  output logic      filling_o      // high while the delay fills
);
  logic [12:0] remain_reg;
  // reload on commit, count samples down to zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      remain_reg <= 13'h0;
    else if (cfg.commit)
      remain_reg <= LEFT ? cfg.delay_l : cfg.delay_r;
    else if (sample_tick_i && remain_reg != 13'h0)
      remain_reg <= remain_reg - 13'h1;
  end
  assign filling_o = (remain_reg != 13'h0);
endmodule

//--- delay_config_commit_regs.sv
/*
  Configuration register file of a stereo audio delay device: control,
  per-channel delay, frame delay, right justified word width and commit.
  Assumes an upstream serial-control slave that has already matched the
  device address and presents each byte as a one-cycle strobe; the first
  data byte of a write is delivered as a pointer load. sample_tick_i is a
  one-cycle pulse per audio sample, synchronous to sys_clk_i.

  // Operation
  // - word width used only in right justified
  // - widths above twenty-four clamp to twenty-four
  // - width field decodes as a plain count
  // - commit bit one copies settings to engine
  // - commit bit zero and upper bits do nothing
  // - format, delays and width move together
  // - channel muted until new delay fills
  // - control mute bits act immediately
  // - frame mode ignores per-channel delay registers
  // - sequential read runs control through commit
  // - format code 01 selects right justified
  // - frame register top bit enables frame delay
*/
`timescale 1ns/1ps
module delay_config_commit_regs (
  input  wire logic        sys_clk_i,     // system clock, 50 MHz
  input  wire logic        rst_i,         // synchronous reset, high
  input  wire logic        ptr_load_i,    // pulse: load register pointer
  input  wire logic [7:0]  ptr_addr_i,    // pointer value with ptr_load_i
  input  wire logic        wr_stb_i,      // pulse: write one data byte
  input  wire logic [7:0]  wr_data_i,     // data with wr_stb_i
  input  wire logic        rd_stb_i,      // pulse: read one data byte
  input  wire logic        sample_tick_i, // pulse: one audio sample passed
  output logic      [7:0]  rd_data_o,     // read byte, valid with rd_valid_o
  output logic             rd_valid_o,    // pulse: rd_data_o is fresh
  output logic      [1:0]  fmt_o,         // committed stream format
  output logic      [4:0]  word_width_o,  // committed effective word width
  output logic      [12:0] delay_left_o,  // committed left delay, samples
  output logic      [12:0] delay_right_o, // committed right delay, samples
  output logic             mute_left_o,   // left channel muted
  output logic             mute_right_o,  // right channel muted
  output logic             commit_o       // pulse: new settings in engine
);
  logic [7:0] ptr_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] rdly_hi_reg;
  logic [7:0] rdly_lo_reg;
  logic [7:0] ldly_hi_reg;
  logic [7:0] ldly_lo_reg;
  logic [7:0] frame_reg;
  logic [7:0] width_reg;
  logic [7:0] commit_reg;
  logic [7:0] rd_data_next;
  logic       commit_req;
  logic       fill_l;
  logic       fill_r;

  engine_cfg_if cfg ();

  // register pointer: load wins over the per-byte step
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      ptr_reg <= delay_cfg_pkg::OFS_CONTROL;
    else if (ptr_load_i)
      ptr_reg <= ptr_addr_i;
    else if (wr_stb_i || rd_stb_i)
      ptr_reg <= ptr_reg + 8'h01;
  end

  // byte writes land at the pointer; unmapped offsets are dropped
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= delay_cfg_pkg::REG_RESET;
      rdly_hi_reg <= delay_cfg_pkg::REG_RESET;
      rdly_lo_reg <= delay_cfg_pkg::REG_RESET;
      ldly_hi_reg <= delay_cfg_pkg::REG_RESET;
      ldly_lo_reg <= delay_cfg_pkg::REG_RESET;
      frame_reg   <= delay_cfg_pkg::REG_RESET;
      width_reg   <= delay_cfg_pkg::REG_RESET;
      commit_reg  <= delay_cfg_pkg::REG_RESET;
    end else if (wr_stb_i && !ptr_load_i) begin
      case (ptr_reg)
        delay_cfg_pkg::OFS_CONTROL:    ctrl_reg    <= wr_data_i;
        delay_cfg_pkg::OFS_RDELAY_HI:  rdly_hi_reg <= wr_data_i;
        delay_cfg_pkg::OFS_RDELAY_LO:  rdly_lo_reg <= wr_data_i;
        delay_cfg_pkg::OFS_LDELAY_HI:  ldly_hi_reg <= wr_data_i;
        delay_cfg_pkg::OFS_LDELAY_LO:  ldly_lo_reg <= wr_data_i;
        delay_cfg_pkg::OFS_FRAME:      frame_reg   <= wr_data_i;
        delay_cfg_pkg::OFS_WORD_WIDTH: width_reg   <= wr_data_i;
        delay_cfg_pkg::OFS_COMMIT:     commit_reg  <= wr_data_i;
        default: ;
      endcase
    end
  end

  // only bit zero of the commit byte triggers; the rest is stored only
  assign commit_req = wr_stb_i && !ptr_load_i && (ptr_reg == delay_cfg_pkg::OFS_COMMIT)
                      && wr_data_i[delay_cfg_pkg::COMMIT_BIT];

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (ptr_reg)
      delay_cfg_pkg::OFS_CONTROL:    rd_data_next = ctrl_reg;
      delay_cfg_pkg::OFS_RDELAY_HI:  rd_data_next = rdly_hi_reg;
      delay_cfg_pkg::OFS_RDELAY_LO:  rd_data_next = rdly_lo_reg;
      delay_cfg_pkg::OFS_LDELAY_HI:  rd_data_next = ldly_hi_reg;
      delay_cfg_pkg::OFS_LDELAY_LO:  rd_data_next = ldly_lo_reg;
      delay_cfg_pkg::OFS_FRAME:      rd_data_next = frame_reg;
      delay_cfg_pkg::OFS_WORD_WIDTH: rd_data_next = width_reg;
      delay_cfg_pkg::OFS_COMMIT:     rd_data_next = commit_reg;
      default:                       rd_data_next = 8'h00;
    endcase
  end

  // read answer registered one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_stb_i && !ptr_load_i;
      if (rd_stb_i && !ptr_load_i)
        rd_data_o <= rd_data_next;
    end
  end

  // transfer into the engine happens in one step here
  settings_commit_unit u_commit (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .commit_req_i (commit_req),
    .ctrl_i       (ctrl_reg),
    .rdly_hi_i    (rdly_hi_reg),
    .rdly_lo_i    (rdly_lo_reg),
    .ldly_hi_i    (ldly_hi_reg),
    .ldly_lo_i    (ldly_lo_reg),
    .frame_i      (frame_reg),
    .width_i      (width_reg),
    .cfg          (cfg)
  );

  // one fill timer per channel, reloaded by each commit
  channel_mute_timer #(.LEFT(1'b1)) u_fill_l (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .sample_tick_i (sample_tick_i),
    .cfg           (cfg),
    .filling_o     (fill_l)
  );

  channel_mute_timer #(.LEFT(1'b0)) u_fill_r (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .sample_tick_i (sample_tick_i),
    .cfg           (cfg),
    .filling_o     (fill_r)
  );

  // engine settings are already flops inside the commit unit
  assign fmt_o         = cfg.fmt;
  assign word_width_o  = cfg.word_width;
  assign delay_left_o  = cfg.delay_l;
  assign delay_right_o = cfg.delay_r;
  assign commit_o      = cfg.commit;

  // mute: control bits act at once, fill mute from the timers;
  // registered so the pins never glitch while the OR settles
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mute_left_o  <= 1'b0;
      mute_right_o <= 1'b0;
    end else begin
      mute_left_o  <= ctrl_reg[delay_cfg_pkg::CTRL_MUTE_L_BIT] || fill_l;
      mute_right_o <= ctrl_reg[delay_cfg_pkg::CTRL_MUTE_R_BIT] || fill_r;
    end
  end

  chk_clamp_width:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req && ctrl_reg[1:0] == delay_cfg_pkg::RIGHT_JUSTIFIED_FORMAT
    && width_reg[5:0] > 6'h18
    |=> word_width_o == 5'h18)
    else $error("word width above limit not clamped");

  chk_width_plain:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req && ctrl_reg[1:0] == delay_cfg_pkg::RIGHT_JUSTIFIED_FORMAT
    && width_reg[5:0] <= 6'h18
    |=> word_width_o == $past(width_reg[4:0]))
    else $error("word width not decoded directly");

  chk_width_fmt_only:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    fmt_o != delay_cfg_pkg::RIGHT_JUSTIFIED_FORMAT |-> word_width_o == 5'h00)
    else $error("word width applied outside right justified format");

  chk_commit_fires:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_stb_i && !ptr_load_i && ptr_reg == 8'h08 && wr_data_i[0] |=> commit_o)
    else $error("commit write did not reach the engine");

  chk_commit_idle:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !commit_o |-> $stable(delay_left_o) && $stable(delay_right_o)
      && $stable(fmt_o) && $stable(word_width_o))
    else $error("engine settings changed without a commit");

  chk_commit_delay:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req && !frame_reg[7]
    |=> delay_left_o == {$past(ldly_hi_reg[4:0]), $past(ldly_lo_reg)}
        && delay_right_o == {$past(rdly_hi_reg[4:0]), $past(rdly_lo_reg)}
        && fmt_o == $past(ctrl_reg[1:0]))
    else $error("committed settings do not match registers");

  chk_fill_mute:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_o && delay_left_o != 13'h0 |-> ##2 mute_left_o)
    else $error("left channel not muted while delay fills");

  chk_mute_direct:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_stb_i && !ptr_load_i && ptr_reg == 8'h01 && wr_data_i[7]
    |-> ##2 mute_right_o)
    else $error("right mute bit did not act without commit");

  chk_ptr_step:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_stb_i || rd_stb_i) && !ptr_load_i |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("register pointer did not step by one");

  chk_read_data:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stb_i && !ptr_load_i && ptr_reg == 8'h08 |=> rd_valid_o && rd_data_o == $past(commit_reg))
    else $error("read of commit register returned wrong byte");

  // register port: pointer, read answer and commit byte handling
  chk_load_wins:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ptr_load_i |=> ptr_reg == $past(ptr_addr_i))
    else $error("pointer load did not take the new value");

  chk_read_pulse:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_valid_o == ($past(rd_stb_i) && !$past(ptr_load_i)))
    else $error("read answer pulse out of step with the strobe");

  chk_read_hold:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(rd_stb_i && !ptr_load_i) |=> $stable(rd_data_o))
    else $error("read byte changed without a read strobe");

  chk_unmapped_zero:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stb_i && !ptr_load_i && (ptr_reg == 8'h00 || ptr_reg > 8'h08)
    |=> rd_data_o == 8'h00)
    else $error("unmapped read returned a nonzero byte");

  chk_commit_follow:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_o == $past(commit_req))
    else $error("commit pulse out of step with the request");

  chk_commit_zero:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_stb_i && !ptr_load_i && ptr_reg == 8'h08 && !wr_data_i[0] |=> !commit_o)
    else $error("commit byte with bit zero low started a transfer");

  chk_commit_store:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_stb_i && !ptr_load_i && ptr_reg == 8'h08 |=> commit_reg == $past(wr_data_i))
    else $error("commit byte not stored");

  // engine side: width ceiling, frame mode, fill and direct mutes
  chk_width_limit:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    word_width_o <= 5'h18)
    else $error("engine word width above the limit");

  chk_frame_equal:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req && frame_reg[delay_cfg_pkg::FRAME_EN_BIT]
    |=> delay_left_o == delay_right_o)
    else $error("frame mode left the channel delays unequal");

  chk_fill_right:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_o && delay_right_o != 13'h0 |-> ##2 mute_right_o)
    else $error("right channel not muted while delay fills");

  chk_mute_left:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_stb_i && !ptr_load_i && ptr_reg == 8'h01 && wr_data_i[6]
    |-> ##2 mute_left_o)
    else $error("left mute bit did not act without commit");

  chk_unmute_left:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !ctrl_reg[delay_cfg_pkg::CTRL_MUTE_L_BIT] && !fill_l |=> !mute_left_o)
    else $error("left channel stayed muted after fill and mute cleared");

  cov_commit: cover property (@(posedge sys_clk_i) disable iff (rst_i) commit_o);
  cov_frame_commit: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req && frame_reg[7]);
  cov_seq_read: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stb_i && ptr_reg == 8'h07 ##[1:20] rd_stb_i && ptr_reg == 8'h08);
  cov_fill_done: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    fill_l ##1 !fill_l);
  cov_clamp_commit: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    commit_req && ctrl_reg[1:0] == 2'h1 && width_reg[5:0] > 6'h18);
endmodule

//--- host_model.sv
/*
  Host side of the register port: pointer loads, write and read strobes,
  as the serial-control slave presents them after its address match.
  Assumes every input of the block is changed on the falling clock edge.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       sys_clk_i,  // system clock
  input  wire logic [7:0] rd_data_i,  // read byte from the device
  input  wire logic       rd_valid_i, // read byte is fresh
  output logic            ptr_load_o, // pointer load pulse
  output logic      [7:0] ptr_addr_o, // pointer value
  output logic            wr_stb_o,   // write strobe
  output logic      [7:0] wr_data_o,  // write byte
  output logic            rd_stb_o    // read strobe
);
  // idle port at time zero
  initial begin
    ptr_load_o = 1'b0;
    ptr_addr_o = 8'h00;
    wr_stb_o   = 1'b0;
    wr_data_o  = 8'h00;
    rd_stb_o   = 1'b0;
  end

  // released lines show the inverse, so stale values never pass
  task automatic load(input logic [7:0] a);
    @(negedge sys_clk_i);
    ptr_load_o = 1'b1;
    ptr_addr_o = a;
    @(negedge sys_clk_i);
    ptr_load_o = 1'b0;
    ptr_addr_o = ~a;
  endtask

  // one byte; held across the taking edge
  task automatic wr(input logic [7:0] d);
    @(negedge sys_clk_i);
    wr_stb_o  = 1'b1;
    wr_data_o = d;
    @(negedge sys_clk_i);
    wr_stb_o  = 1'b0;
    wr_data_o = ~d;
  endtask

  // a single read ends after one byte, no further strobe
  task automatic rd(output logic [7:0] d, output logic v);
    @(negedge sys_clk_i);
    rd_stb_o = 1'b1;
    @(negedge sys_clk_i);
    rd_stb_o = 1'b0;
    d = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule

//--- delay_config_commit_regs_test.sv
/*
  Self-checking bench for the delay configuration register block.
  Assumes host_model drives the register port; sample ticks come from here.
*/
`timescale 1ns/1ps
module delay_config_commit_regs_test;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sample_tick_i = 1'b0;
  logic        ptr_load, wr_stb, rd_stb, rd_valid, mute_l, mute_r, commit;
  logic [7:0]  ptr_addr, wr_data, rd_data, ptr_e, d;
  logic [1:0]  fmt, fmt_e;
  logic [4:0]  word_width, ww_e;
  logic [12:0] delay_l, delay_r, dl_e, dr_e;
  logic [7:0]  regs_exp [1:8];
  logic [31:0] r;
  logic        v;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          seed = 32'h37db;
  int          wtab [6] = '{0, 1, 24, 25, 63, 16};

  always #10 sys_clk_i = ~sys_clk_i;

  host_model host_u (.sys_clk_i(sys_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .ptr_load_o(ptr_load), .ptr_addr_o(ptr_addr), .wr_stb_o(wr_stb), .wr_data_o(wr_data),
    .rd_stb_o(rd_stb));

  delay_config_commit_regs dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .ptr_load_i(ptr_load), .ptr_addr_i(ptr_addr), .wr_stb_i(wr_stb), .wr_data_i(wr_data),
    .rd_stb_i(rd_stb), .sample_tick_i(sample_tick_i), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .fmt_o(fmt), .word_width_o(word_width), .delay_left_o(delay_l),
    .delay_right_o(delay_r), .mute_left_o(mute_l), .mute_right_o(mute_r), .commit_o(commit));

  task automatic close_out();
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far above the roughly six hundred cycles needed
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_val({12'h000, got}, {12'h000, exp}, what);
  endtask

  // frame mode replaces both channel delays, clamped to the maximum
  function automatic logic [12:0] exp_dly(input logic [7:0] hi, lo, fr);
    int s;
    if (!fr[delay_cfg_pkg::FRAME_EN_BIT])
      return {hi[4:0], lo};
    s = (int'(fr[2:0]) + 1) * delay_cfg_pkg::FS10_TAB[fr[5:3]] * 1000
        / (fr[6] ? delay_cfg_pkg::RATE100_60 : delay_cfg_pkg::RATE100_50);
    return (s > 8191) ? 13'h1FFF : s[12:0];
  endfunction

  task automatic take_commit();
    fmt_e = regs_exp[1][1:0];
    ww_e = (fmt_e != delay_cfg_pkg::RIGHT_JUSTIFIED_FORMAT) ? 5'h00 :
           (regs_exp[7][5:0] > delay_cfg_pkg::WW_MAX) ? 5'h18 : regs_exp[7][4:0];
    dr_e = exp_dly(regs_exp[2], regs_exp[3], regs_exp[6]);
    dl_e = exp_dly(regs_exp[4], regs_exp[5], regs_exp[6]);
  endtask

  task automatic chk_engine();
    chk_val(13'(fmt), 13'(fmt_e), "format");
    chk_val(13'(word_width), 13'(ww_e), "word width");
    chk_val(delay_l, dl_e, "left delay");
    chk_val(delay_r, dr_e, "right delay");
  endtask

  task automatic go(input logic [7:0] a);
    host_u.load(a);
    ptr_e = a;
  endtask

  // write at the pointer, mirror it, step the pointer
  task automatic put(input logic [7:0] x);
    host_u.wr(x);
    if (ptr_e >= 8'h01 && ptr_e <= 8'h08)
      regs_exp[ptr_e] = x;
    ptr_e = ptr_e + 8'h01;
  endtask

  task automatic read_all();
    go(8'h01);
    for (int a = 1; a <= 8; a++) begin
      host_u.rd(d, v);
      chk_flag(v, 1'b1, "read valid");
      chk_val(13'(d), 13'(regs_exp[a]), "read back");
    end
  endtask

  initial begin
    for (int a = 1; a <= 8; a++)
      regs_exp[a] = 8'h00;
    take_commit();
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk_engine();
    chk_flag(mute_l | mute_r | commit, 1'b0, "idle after reset");
    read_all();
    // every format, width corners, frame corners, random delays
    for (int i = 0; i < 12; i++) begin
      go(8'h01);
      r = $random(seed);
      put({6'h00, i < 6 ? 2'h1 : 2'(i % 4)});
      put({3'h0, r[4:0]});
      put(r[15:8]);
      put({3'h0, r[20:16]});
      put(r[31:24]);
      r = $random(seed);
      put(i == 0 ? 8'hFF : i == 1 ? 8'h90 : i == 2 ? 8'h00 : r[7:0]);
      put(i < 6 ? 8'(wtab[i]) : {2'h0, r[13:8]});
      chk_engine();
      put({r[23:17], 1'b0});
      chk_flag(commit, 1'b0, "commit with bit0 low");
      chk_engine();
      go(8'h08);
      put({r[31:25], 1'b1});
      chk_flag(commit, 1'b1, "commit pulse");
      take_commit();
      chk_engine();
      @(negedge sys_clk_i);
      chk_flag(commit, 1'b0, "commit one cycle");
      read_all();
    end
    // fill: left 3 samples, right 5 samples, committed in one burst
    go(8'h01);
    put(8'h00);
    put(8'h00);
    put(8'h05);
    put(8'h00);
    put(8'h03);
    put(8'h00);
    put(8'h00);
    put(8'h01);
    take_commit();
    chk_engine();
    repeat (3) @(negedge sys_clk_i);
    chk_flag(mute_l & mute_r, 1'b1, "muted while filling");
    for (int k = 1; k <= 6; k++) begin
      @(negedge sys_clk_i);
      sample_tick_i = 1'b1;
      @(negedge sys_clk_i);
      sample_tick_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk_flag(mute_l, k < 3, "left fill");
      chk_flag(mute_r, k < 5, "right fill");
    end
    // control mute bits act without a commit
    for (int m = 0; m < 4; m++) begin
      go(8'h01);
      put({2'(m), 6'h01});
      @(negedge sys_clk_i);
      chk_flag(mute_l, m[0], "left mute direct");
      chk_flag(mute_r, m[1], "right mute direct");
      chk_engine();
    end
    // unmapped place: write dropped, read gives zero
    go(8'h09);
    put(8'h5A);
    go(8'h09);
    host_u.rd(d, v);
    chk_val(13'(d), 13'h0000, "unmapped read");
    close_out();
  end
endmodule
